// ### rtl/fecs_map.vh
// Register indexes, field positions and reset values of the NVM command and status block.
// Assumes byte address = 4 * index on a 32-bit AXI4-Lite bus, data in byte lane 0.
`ifndef FECS_MAP_VH
`define FECS_MAP_VH

// ****************************************
// Register indexes
// ****************************************
`define FECS_IDX_DIV      14'h1820
`define FECS_IDX_OPT      14'h1821
`define FECS_IDX_CFG      14'h1823
`define FECS_IDX_PROT     14'h1824
`define FECS_IDX_STAT     14'h1825
`define FECS_IDX_CMD      14'h1826
`define FECS_IDX_IRQST    14'h1828
`define FECS_IDX_IRQMSK   14'h1829

// ****************************************
// Field positions
// ****************************************
`define FECS_DIV_LOADED   7
`define FECS_OPT_KEYEN    7
`define FECS_OPT_SECMODE  5
`define FECS_CFG_PAGESEL  6
`define FECS_CFG_KEY_ACCESS_ENABLE   5
`define FECS_ST_EMPTY     7
`define FECS_ST_DONE      6
`define FECS_ST_PVIOL     5
`define FECS_ST_ACCERR    4
`define FECS_ST_BLANK     2
`define FECS_IRQ_DONE     0
`define FECS_IRQ_PVIOL    1
`define FECS_IRQ_ACCERR   2
`define FECS_IRQ_BLANK    3

// ****************************************
// Values and reset values
// ****************************************
`define FECS_SEC_OPEN     2'h2
`define FECS_SEC_RST      2'h0
`define FECS_CFG_FIXED    8'h11
`define FECS_PROT_RST     8'hFF
`define FECS_KEY_BLOCK    13'h1FF6
`define FECS_RESP_OKAY    2'h0
`define FECS_RESP_SLVERR  2'h2
`define FECS_SEQ_IDLE     3'h1
`define FECS_SEQ_DATA     3'h2
`define FECS_SEQ_CMD      3'h4

`endif

// ### rtl/fecs_flash_eeprom_command_status.v
// NVM command sequencer: registers, command launch, one-entry burst buffer, flags, security.
// Assumes a single clock, AXI4-Lite master on the register side, and an array engine
// that answers each arrayStart with one arrayDone pulse.
//
// Behaviour
// - Sector mode bit selects split sector over two pages or one page.
// - Two-bit security code is unsecured only at value 1:0.
// - While secure, untrusted memory and debug accesses are never granted.
// - Correct backdoor key or passed blank check sets security code to 1:0.
// - Page select bit chooses which EEPROM page is visible; other page hidden.
// - Key access bit routes key range writes to key compare or command start.
// - Writing 1 to buffer empty flag launches; flag clears then, sets again on transfer.
// - Only burst program buffers; empty flag shows room for another burst.
// - Complete flag set when idle and empty, cleared on launch, not writable.
// - Protected target ignores command, sets violation flag; write 1 clears it.
// - Sequence errors, undivided clock or stop while active set access error.
// - Write 1 clears access error flag; writing 0 does nothing.
// - Blank flag set after passing blank check, cleared on next valid launch.
// - Only six command codes are legal; any other raises access error.
`timescale 1ns/10ps
`include "fecs_map.vh"

module fecs_flash_eeprom_command_status #(
  parameter [7:0] CMD_BLANK = 8'h01,
  parameter [7:0] CMD_BYTE  = 8'h02,
  parameter [7:0] CMD_BURST = 8'h03,
  parameter [7:0] CMD_PAGE  = 8'h04,
  parameter [7:0] CMD_MASS  = 8'h05,
  parameter [7:0] CMD_SPARE = 8'h06
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  input  wire [15:0] awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [15:0] araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire [1:0]  strapSecurity,
  input  wire        strapSectorMode,
  input  wire        strapKeyEnable,
  input  wire [63:0] backdoorKey,
  input  wire        memWrValid,
  input  wire [15:0] memWrAddr,
  input  wire [7:0]  memWrData,
  input  wire        untrustedReq,
  input  wire        stopReq,
  input  wire        arrayDone,
  input  wire        arrayBlank,
  output reg         untrustedGrant,
  output reg         eepromSectorMode,
  output reg         eepromPageSelect,
  output reg         secure,
  output reg         arrayStart,
  output reg         arrayAbort,
  output reg  [7:0]  arrayCmd,
  output reg  [15:0] arrayAddr,
  output reg  [7:0]  arrayData,
  output reg  [6:0]  clockDivider,
  output reg         irq
);

  // ****************************************
  // Functions
  // ****************************************
  // Six recognised codes
  function isLegal;
    input [7:0] c;
    begin
      isLegal = (c == CMD_BLANK) | (c == CMD_BYTE) | (c == CMD_BURST) |
                (c == CMD_PAGE) | (c == CMD_MASS) | (c == CMD_SPARE);
    end
  endfunction

  // Everything except blank check alters the array
  function isModify;
    input [7:0] c;
    begin
      isModify = (c != CMD_BLANK);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [15:0] awAddrQ;
  reg [7:0]  wByteQ;
  reg        wLaneQ;
  reg        divLoaded;
  reg [1:0]  securityCode;
  reg        keyEnable;
  reg        strapsTaken;
  reg        keyAccess;
  reg [7:0]  protection;
  reg        pviol;
  reg        accerr;
  reg        blank;
  reg        complete;
  reg        busy;
  reg        bufFull;
  reg [2:0]  seq;
  reg [7:0]  seqCmdCode;
  reg [15:0] seqAddr;
  reg [7:0]  seqData;
  reg [7:0]  keyGood;
  reg        keyBad;
  reg [3:0]  irqStatus;
  reg [3:0]  irqMask;
  reg [31:0] rdNext;
  reg        rdHit;

  wire        doWrite  = ~awready & ~wready & ~bvalid;
  wire [13:0] wIdx     = awAddrQ[15:2];
  wire        wAligned = (awAddrQ[1:0] == 2'h0);
  wire        wHit     = wAligned & ((wIdx == `FECS_IDX_DIV) | (wIdx == `FECS_IDX_OPT) |
                         (wIdx == `FECS_IDX_CFG) | (wIdx == `FECS_IDX_PROT) | (wIdx == `FECS_IDX_STAT) |
                         (wIdx == `FECS_IDX_CMD) | (wIdx == `FECS_IDX_IRQST) | (wIdx == `FECS_IDX_IRQMSK));
  wire        wEn      = doWrite & wLaneQ & wAligned;
  wire        wrStat   = wEn & (wIdx == `FECS_IDX_STAT);
  wire        wrCmd    = wEn & (wIdx == `FECS_IDX_CMD);

  // ****************************************
  // Command sequence decode
  // ****************************************
  wire inKeyRange = (memWrAddr[15:3] == `FECS_KEY_BLOCK);
  wire keyWr      = memWrValid & keyAccess & inKeyRange;
  wire arrWr      = memWrValid & ~(keyAccess & inKeyRange);
  wire burstRun   = busy & (arrayCmd == CMD_BURST);
  wire flagsBlock = pviol | accerr;
  wire launchReq  = wrStat & wByteQ[`FECS_ST_EMPTY] & ~flagsBlock;
  wire errData    = arrWr & ((seq != `FECS_SEQ_IDLE) | bufFull | (busy & ~burstRun));
  wire errCmd     = wrCmd & ((seq != `FECS_SEQ_DATA) | ~isLegal(wByteQ));
  wire errLaunch  = launchReq & (seq != `FECS_SEQ_CMD);
  // Only a burst may queue behind a running burst
  wire errBuffer  = launchReq & busy & ~(burstRun & (seqCmdCode == CMD_BURST));
  wire errDivider = launchReq & isModify(seqCmdCode) & ~divLoaded;
  wire protHit    = ~protection[0] & (seqAddr[15:9] >= protection[7:1]);
  wire pvSet      = launchReq & ~errLaunch & ~errBuffer & ~errDivider &
                    isModify(seqCmdCode) & protHit;
  wire stopErr    = stopReq & (busy | bufFull);
  wire aeSet      = errData | errCmd | errLaunch | errBuffer | errDivider | stopErr;
  wire launchNow  = launchReq & ~errLaunch & ~errBuffer & ~errDivider & ~pvSet;
  wire transfer   = bufFull & (~busy | arrayDone) & ~stopErr;
  wire blankPass  = busy & arrayDone & (arrayCmd == CMD_BLANK) & arrayBlank;
  wire idleNow    = ~(launchNow | bufFull | busy);
  wire keyAllOk   = (keyGood == 8'hFF) & ~keyBad & keyEnable;
  wire [3:0] evts = {blankPass & ~blank, aeSet & ~accerr, pvSet & ~pviol, idleNow & ~complete};

  // ****************************************
  // Read mux
  // ****************************************
  // Reserved bits read as zero, except CFG bits 4 and 0 fixed at one; unmapped words read as zero
  always @* begin
    rdNext = 32'h0;
    rdHit  = (araddr[1:0] == 2'h0);
    case (araddr[15:2])
      `FECS_IDX_DIV:    rdNext[7:0] = {divLoaded, clockDivider};
      `FECS_IDX_OPT:    rdNext[7:0] = {keyEnable, 1'b0, eepromSectorMode, 3'h0, securityCode};
      `FECS_IDX_CFG:    rdNext[7:0] = `FECS_CFG_FIXED | {1'b0, eepromPageSelect, keyAccess, 5'h0};
      `FECS_IDX_PROT:   rdNext[7:0] = protection;
      `FECS_IDX_STAT:   rdNext[7:0] = {~bufFull, complete, pviol, accerr, 1'b0, blank, 2'h0};
      `FECS_IDX_CMD:    rdNext[7:0] = seqCmdCode;
      `FECS_IDX_IRQST:  rdNext[3:0] = irqStatus;
      `FECS_IDX_IRQMSK: rdNext[3:0] = irqMask;
      default:          rdHit = 1'b0;
    endcase
  end

  // ****************************************
  // AXI4-Lite handshakes
  // ****************************************
  // Address and data held until both arrive, then one write and a response
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `FECS_RESP_OKAY;
      awAddrQ <= 16'h0000;
      wByteQ  <= 8'h00;
      wLaneQ  <= 1'b0;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `FECS_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        awAddrQ <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wByteQ <= wdata[7:0];
        wLaneQ <= wstrb[0];
        wready <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= wHit ? `FECS_RESP_OKAY : `FECS_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rdNext;
        rresp   <= rdHit ? `FECS_RESP_OKAY : `FECS_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Control, flags and execution
  // ****************************************
  // Straps are caught on the first enabled edge after release, never by the reset itself
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strapsTaken      <= 1'b0;
      securityCode     <= `FECS_SEC_RST;
      keyEnable        <= 1'b0;
      eepromSectorMode <= 1'b0;
      divLoaded        <= 1'b0;
      clockDivider     <= 7'h00;
      keyAccess        <= 1'b0;
      eepromPageSelect <= 1'b0;
      protection       <= `FECS_PROT_RST;
      pviol            <= 1'b0;
      accerr           <= 1'b0;
      blank            <= 1'b0;
      complete         <= 1'b1;
      busy             <= 1'b0;
      bufFull          <= 1'b0;
      seq              <= `FECS_SEQ_IDLE;
      seqCmdCode       <= 8'h00;
      seqAddr          <= 16'h0000;
      seqData          <= 8'h00;
      keyGood          <= 8'h00;
      keyBad           <= 1'b0;
      arrayStart       <= 1'b0;
      arrayAbort       <= 1'b0;
      arrayCmd         <= 8'h00;
      arrayAddr        <= 16'h0000;
      arrayData        <= 8'h00;
      irqStatus        <= 4'h0;
      irqMask          <= 4'h0;
      irq              <= 1'b0;
      secure           <= 1'b1;
      untrustedGrant   <= 1'b0;
    end else if (ce) begin
      arrayStart <= 1'b0;
      arrayAbort <= 1'b0;
      if (!strapsTaken) begin
        strapsTaken      <= 1'b1;
        securityCode     <= strapSecurity;
        eepromSectorMode <= strapSectorMode;
        keyEnable        <= strapKeyEnable;
      end else if (keyAllOk || blankPass) begin
        securityCode <= `FECS_SEC_OPEN;
      end
      secure         <= (securityCode != `FECS_SEC_OPEN);
      untrustedGrant <= untrustedReq & (securityCode == `FECS_SEC_OPEN);
      // Plain register writes
      if (wEn && wIdx == `FECS_IDX_DIV && !divLoaded) begin
        clockDivider <= wByteQ[6:0];
        divLoaded    <= 1'b1;
      end
      if (wEn && wIdx == `FECS_IDX_CFG) begin
        eepromPageSelect <= wByteQ[`FECS_CFG_PAGESEL];
        keyAccess        <= wByteQ[`FECS_CFG_KEY_ACCESS_ENABLE];
      end
      if (wEn && wIdx == `FECS_IDX_PROT && !busy && !bufFull)
        protection <= wByteQ;
      if (wEn && wIdx == `FECS_IDX_IRQMSK)
        irqMask <= wByteQ[3:0];
      // Key compare, one bit per byte slot; leaving key mode restarts it
      if (!keyAccess || keyAllOk) begin
        keyGood <= 8'h00;
        keyBad  <= 1'b0;
      end else if (keyWr) begin
        keyGood[memWrAddr[2:0]] <= 1'b1;
        if (memWrData != backdoorKey[{memWrAddr[2:0], 3'h0} +: 8])
          keyBad <= 1'b1;
      end
      // Sequence: array write, command write, launch
      if (aeSet || pvSet || launchNow) begin
        seq <= `FECS_SEQ_IDLE;
      end else if (arrWr) begin
        seq     <= `FECS_SEQ_DATA;
        seqAddr <= memWrAddr;
        seqData <= memWrData;
      end else if (wrCmd) begin
        seq        <= `FECS_SEQ_CMD;
        seqCmdCode <= wByteQ;
      end
      // Set beats a same-cycle write-1 clear
      accerr <= aeSet | (accerr & ~(wrStat & wByteQ[`FECS_ST_ACCERR]));
      pviol  <= pvSet | (pviol & ~(wrStat & wByteQ[`FECS_ST_PVIOL]));
      if (blankPass)
        blank <= 1'b1;
      else if (launchNow || (busy && arrayDone && arrayCmd == CMD_BLANK))
        blank <= 1'b0;
      complete <= idleNow;
      // Stop aborts everything in flight
      if (stopErr) begin
        busy       <= 1'b0;
        bufFull    <= 1'b0;
        arrayAbort <= 1'b1;
      end else begin
        if (launchNow)
          bufFull <= 1'b1;
        if (transfer) begin
          bufFull    <= 1'b0;
          busy       <= 1'b1;
          arrayStart <= 1'b1;
          arrayCmd   <= seqCmdCode;
          arrayAddr  <= seqAddr;
          arrayData  <= seqData;
        end else if (arrayDone) begin
          busy <= 1'b0;
        end
      end
      // Sticky events, cleared by reading the interrupt status word
      if (arvalid && arready && araddr[15:2] == `FECS_IDX_IRQST && araddr[1:0] == 2'h0)
        irqStatus <= evts;
      else
        irqStatus <= irqStatus | evts;
      irq <= |((irqStatus | evts) & irqMask);
    end
  end

endmodule

// ### tb/fecs_check_sva.sv
// Port checker for the NVM command block, bound to its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
module fecs_check (
  input wire        clk,
  input wire        nrst,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  input wire        untrustedReq,
  input wire        untrustedGrant,
  input wire        secure,
  input wire        stopReq,
  input wire        arrayStart,
  input wire        arrayAbort,
  input wire [7:0]  arrayCmd
);
  // ********
  // Properties
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Write answer lands two edges after both halves are taken
  sequence s_wtake; awvalid && awready && wvalid && wready; endsequence
  sequence s_bans; ##2 bvalid; endsequence
  property p_wr; s_wtake |-> s_bans; endproperty
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_rd; arvalid && arready |=> rvalid; endproperty
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_awbusy; awvalid && awready |=> !awready; endproperty
  // A grant needs a request one edge earlier and an unsecured part
  property p_grant; untrustedGrant |-> !secure && $past(untrustedReq); endproperty
  property p_start; arrayStart |=> !arrayStart; endproperty
  property p_cmd; arrayStart |-> arrayCmd inside {[8'h01:8'h06]}; endproperty
  property p_abort; arrayAbort |-> $past(stopReq); endproperty
  a_wr: assert property (p_wr) else $error("write answer missing");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_rd: assert property (p_rd) else $error("read answer missing");
  a_rhold: assert property (p_rhold) else $error("read data changed");
  a_awbusy: assert property (p_awbusy) else $error("second write taken");
  a_grant: assert property (p_grant) else $error("grant while secure");
  a_start: assert property (p_start) else $error("start too long");
  a_cmd: assert property (p_cmd) else $error("illegal code started");
  a_abort: assert property (p_abort) else $error("abort without stop");
endmodule

bind fecs_flash_eeprom_command_status fecs_check u_chk (.*);

// ### tb/fecs_flash_eeprom_command_status_test.sv
// Self-checking bench of the NVM command block through its AXI4-Lite registers.
// Assumes the checker binds itself and fecs_map.vh is on the include path.
`timescale 1ns/10ps
`include "fecs_map.vh"
module fecs_flash_eeprom_command_status_test;
  // ********
  // Wiring
  // ********
  logic        clk = 1'h0, nrst = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, memWrValid = 1'h0, untrustedReq = 1'h0;
  logic        stopReq = 1'h0, arrayDone = 1'h0, arrayBlank = 1'h0, strapSectorMode = 1'h0;
  logic [1:0]  strapSecurity = 2'h0;
  logic [3:0]  wstrb = 4'hF;
  logic [7:0]  memWrData = 8'h00;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0, memWrAddr = 16'h0;
  logic [31:0] wdata = 32'h0, rnd = 32'h0, stv = 32'h0;
  logic [33:0] got;
  logic [49:0] n;
  logic [63:0] backdoorKey = 64'h0;
  wire         awready, wready, bvalid, arready, rvalid, untrustedGrant, eepromSectorMode;
  wire         eepromPageSelect, secure, arrayStart, arrayAbort, irq;
  wire [1:0]   bresp, rresp;
  wire [6:0]   clockDivider;
  wire [7:0]   arrayCmd, arrayData;
  wire [15:0]  arrayAddr;
  wire [31:0]  rdata;
  int          failures = 0, cmp_count = 0, seed = 32'h214F673C;
  int          aborts = 0;
  logic [49:0] q[$];

  fecs_flash_eeprom_command_status DUT (.ce(1'h1), .strapKeyEnable(1'h1), .*);

  initial forever #5 clk = ~clk;

  // Hang guard, far above the few hundred cycles the run needs
  initial begin
    #300us;
    failures++;
    complete_run;
  end

  // Oldest note is taken off whenever a bus answer is handed over
  always @(posedge clk) if (bvalid && bready || rvalid && rready) begin
    n = q.pop_front();
    cmp_count++;
    got = rvalid ? {rresp, rdata} : {bresp, n[31:0]};
    if (got !== n[33:0]) begin
      failures++;
      $display("CHECK FAILED reg %h exp %h got %h", n[49:34], n[33:0], got);
    end
  end

  // Start and abort pulse for one cycle, so keep what they carried
  always @(posedge clk) begin
    if (arrayStart) stv <= {arrayCmd, arrayAddr, arrayData};
    if (arrayAbort) aborts++;
  end

  // ********
  // Tasks
  // ********
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask

  task complete_run;
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Address and data are offered together and released one by one
  task wr(input [13:0] i, input [7:0] d);
    logic a, w;
    q.push_back({i, 2'h0, 2'h0, 32'h0});
    a = 1'h1;
    w = 1'h1;
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (a || w) begin
      @(posedge clk);
      if (a && awready) begin a = 1'h0; awvalid <= 1'h0; end
      if (w && wready) begin w = 1'h0; wvalid <= 1'h0; end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'h1;
    @(posedge clk);
    bready <= 1'h0;
  endtask

  task rd(input [13:0] i, input [31:0] d, input [1:0] r = 2'h0);
    q.push_back({i, 2'h0, r, d});
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h1;
    @(posedge clk);
    rready <= 1'h0;
  endtask

  task mw(input [15:0] a, input [7:0] d);
    memWrAddr <= a;
    memWrData <= d;
    memWrValid <= 1'h1;
    @(posedge clk);
    memWrValid <= 1'h0;
    @(posedge clk);
  endtask

  // Data write, command code, then launch through the empty flag
  task go(input [7:0] c, input [15:0] a);
    rnd = $random(seed);
    mw(a, rnd[7:0]);
    wr(`FECS_IDX_CMD, c);
    wr(`FECS_IDX_STAT, 8'h80);
    // The start pulse is captured on the same edge that takes the write answer
    @(posedge clk);
  endtask

  task done(input b);
    arrayBlank <= b;
    arrayDone <= 1'h1;
    @(posedge clk);
    arrayDone <= 1'h0;
    @(posedge clk);
  endtask

  task rst(input [1:0] s);
    nrst <= 1'h0;
    strapSecurity <= s;
    strapSectorMode <= s[0];
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    repeat (5) @(posedge clk);
  endtask

  // ********
  // Scenarios
  // ********
  initial begin
    @(posedge clk);
    untrustedReq <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      rst(k[1:0]);
      chk("secure", k != 2, secure);
      chk("sectorMode", k[0], eepromSectorMode);
      chk("grant", k == 2, untrustedGrant);
      rd(`FECS_IDX_OPT, {24'h0, 1'h1, 1'h0, k[0], 3'h0, k[1:0]});
    end
    rd(`FECS_IDX_STAT, 32'hC0);
    rd(`FECS_IDX_PROT, 32'hFF);
    rd(14'h1822, 32'h0, 2'h2);
    // Backdoor key: one wrong byte first, then the right key
    backdoorKey <= {$random(seed), $random(seed)};
    wr(`FECS_IDX_CFG, 8'h60);
    rd(`FECS_IDX_CFG, 32'h71);
    chk("pageSelect", 1, eepromPageSelect);
    for (int p = 0; p < 2; p++) begin
      // A failed attempt stays failed until key mode is left and entered again
      if (p == 1) begin
        wr(`FECS_IDX_CFG, 8'h00);
        wr(`FECS_IDX_CFG, 8'h60);
      end
      for (int j = 0; j < 8; j++) mw(16'hFFB0 + j[15:0], backdoorKey[8*j +: 8] ^ {7'h0, p == 0 && j == 3});
      repeat (3) @(posedge clk);
      chk("secure", p == 0, secure);
    end
    rd(`FECS_IDX_OPT, 32'hA2);
    // Key range now starts a command, refused while the divider is unset
    wr(`FECS_IDX_CFG, 8'h00);
    go(8'h02, 16'hFFB0);
    rd(`FECS_IDX_STAT, 32'hD0);
    wr(`FECS_IDX_DIV, 8'h05);
    wr(`FECS_IDX_DIV, 8'h07);
    rd(`FECS_IDX_DIV, 32'h85);
    chk("divider", 7'h05, clockDivider);
    wr(`FECS_IDX_STAT, 8'h80);
    wr(`FECS_IDX_STAT, 8'h00);
    rd(`FECS_IDX_STAT, 32'hD0);
    chk("start", 32'h0, stv);
    wr(`FECS_IDX_STAT, 8'h10);
    rd(`FECS_IDX_STAT, 32'hC0);
    go(8'h07, 16'h1000);
    rd(`FECS_IDX_STAT, 32'hD0);
    chk("irqMasked", 0, irq);
    rd(`FECS_IDX_IRQST, 32'h4);
    // Every legal code from a fresh secure part; blank check unsecures
    rst(2'h0);
    wr(`FECS_IDX_DIV, 8'h05);
    wr(`FECS_IDX_IRQMSK, 8'h01);
    for (int c = 1; c < 7; c++) begin
      go(c[7:0], 16'h1000 + c[15:0]);
      chk("start", {c[7:0], 16'h1000 + c[15:0], rnd[7:0]}, stv);
      done(c == 1);
      rd(`FECS_IDX_STAT, c == 1 ? 32'hC4 : 32'hC0);
      chk("irq", 1, irq);
      rd(`FECS_IDX_IRQST, c == 1 ? 32'h9 : 32'h1);
      repeat (2) @(posedge clk);
      chk("irqClear", 0, irq);
    end
    chk("secure", 0, secure);
    // Second burst waits in the buffer while the first runs
    go(8'h03, 16'h1100);
    go(8'h03, 16'h1101);
    rd(`FECS_IDX_STAT, 32'h00);
    done(1'h0);
    rd(`FECS_IDX_STAT, 32'h80);
    chk("burstAddr", 16'h1101, stv[23:8]);
    done(1'h0);
    rd(`FECS_IDX_STAT, 32'hC0);
    wr(`FECS_IDX_PROT, 8'h00);
    go(8'h02, 16'h1200);
    rd(`FECS_IDX_STAT, 32'hE0);
    wr(`FECS_IDX_PROT, 8'hFF);
    // A full sequence behind the set violation flag must not start
    go(8'h02, 16'h1300);
    chk("heldAddr", 16'h1101, stv[23:8]);
    wr(`FECS_IDX_STAT, 8'h20);
    rd(`FECS_IDX_STAT, 32'hC0);
    // The kept sequence launches once the flag is clear
    wr(`FECS_IDX_STAT, 8'h80);
    @(posedge clk);
    chk("keptAddr", 16'h1300, stv[23:8]);
    // Stop entry while that byte program runs
    stopReq <= 1'h1;
    @(posedge clk);
    stopReq <= 1'h0;
    rd(`FECS_IDX_STAT, 32'hD0);
    chk("abort", 1, aborts);
    complete_run;
  end
endmodule
